// ### bench/latched_pwm_output_unit_tb.sv
// Bench for the pulse output unit driven over its register bus
`timescale 1ns/1ns
`include "lpo_map.svh"
module latched_pwm_output_unit_tb;
    import lpo_pkg::*;
    logic mclk;
    logic rst_n;
    lpo_axi_req_type axiReq;
    lpo_axi_rsp_type axiRsp;
    logic pinOut;
    logic [15:0] highLen;
    logic [15:0] lowLen;
    logic [15:0] rises;
    int badCount;
    int nChecks;
    lpo_top DUT (.mclk(mclk), .rst_n(rst_n), .axiReq(axiReq),
        .axiRsp(axiRsp), .pinOut(pinOut));
    lpo_load_model LOAD (.mclk(mclk), .rst_n(rst_n), .pinIn(pinOut),
        .highLen(highLen), .lowLen(lowLen), .rises(rises));
    always #5 mclk = ~mclk;
    // --------------------------------------------------
    // Bus and check tasks
    // --------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            badCount++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] expResp = 2'b00);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge mclk);
        axiReq.awvalid <= 1'b1;
        axiReq.awaddr <= a;
        axiReq.wvalid <= 1'b1;
        axiReq.wdata <= d;
        axiReq.wstrb <= 4'hf;
        axiReq.bready <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge mclk);
            if (axiRsp.awready === 1'b1) begin
                awDone = 1'b1;
                axiReq.awvalid <= 1'b0;
            end
            if (axiRsp.wready === 1'b1) begin
                wDone = 1'b1;
                axiReq.wvalid <= 1'b0;
            end
        end
        while (axiRsp.bvalid !== 1'b1) @(posedge mclk);
        chk("bresp", {30'h0, expResp}, {30'h0, axiRsp.bresp});
        axiReq.bready <= 1'b0;
    endtask
    task automatic rd(input string name, input logic [7:0] a,
        input logic [31:0] exp, input logic [1:0] expResp = 2'b00);
        @(posedge mclk);
        axiReq.arvalid <= 1'b1;
        axiReq.araddr <= a;
        axiReq.rready <= 1'b1;
        do @(posedge mclk); while (axiRsp.arready !== 1'b1);
        axiReq.arvalid <= 1'b0;
        while (axiRsp.rvalid !== 1'b1) @(posedge mclk);
        chk(name, exp, axiRsp.rdata);
        chk("rresp", {30'h0, expResp}, {30'h0, axiRsp.rresp});
        axiReq.rready <= 1'b0;
    endtask
    task automatic waitRise();
        logic [15:0] r;
        r = rises;
        while (rises === r) @(posedge mclk);
    endtask
    task automatic pinIs(input logic exp);
        repeat (3) @(posedge mclk);
        chk("pinOut", {31'h0, exp}, {31'h0, pinOut});
    endtask
    task automatic phases(input logic [15:0] hi, input logic [15:0] lo);
        repeat (3) waitRise();
        chk("highLen", {16'h0, hi}, {16'h0, highLen});
        chk("lowLen", {16'h0, lo}, {16'h0, lowLen});
    endtask
    task automatic latency(output int n);
        n = 0;
        while (pinOut !== 1'b1) begin
            @(posedge mclk);
            n++;
        end
    endtask
    task tally_and_finish();
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // --------------------------------------------------
    // Watchdog
    // --------------------------------------------------
    initial begin
        repeat (20000) @(posedge mclk);
        badCount++;
        $display("ERROR watchdog expired");
        tally_and_finish();
    end
    // --------------------------------------------------
    // Main sequence
    // --------------------------------------------------
    initial begin
        logic [15:0] r0;
        int t0;
        int t5;
        int tick;
        tick = `LPO_TICK_CYC;
        mclk = 1'b0;
        rst_n = 1'b0;
        axiReq = '0;
        badCount = 0;
        nChecks = 0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        pinIs(1'b0);
        rd("ctrl", `LPO_OFS_CTRL, 32'h0);
        rd("stat", `LPO_OFS_STAT, 32'h0);
        rd("count", `LPO_OFS_COUNT, `LPO_RST_COUNT);
        rd("period", `LPO_OFS_PERIOD, `LPO_RST_PERIOD);
        rd("high", `LPO_OFS_HIGH, `LPO_RST_HIGH);
        rd("unmapped", 8'h1c, 32'h0, 2'b10);
        wr(8'h1c, 32'hffff_ffff, 2'b10);
        wr(`LPO_OFS_CTRL, 32'h0000_0040);
        pinIs(1'b1);
        wr(`LPO_OFS_CTRL, 32'h0000_0041);
        pinIs(1'b0);
        wr(`LPO_OFS_CTRL, 32'h0000_0011);
        pinIs(1'b1);
        // Held values stay out until a commit
        wr(`LPO_OFS_PERIOD, 32'h4);
        wr(`LPO_OFS_HIGH, 32'h1);
        wr(`LPO_OFS_CTRL, 32'h0000_0033);
        phases(16'(tick), 16'(tick));
        rd("stat", `LPO_OFS_STAT, 32'h1);
        wr(`LPO_OFS_CTRL, 32'h0000_0037);
        phases(16'(tick), 16'(3 * tick));
        wr(`LPO_OFS_PERIOD, 32'h8);
        wr(`LPO_OFS_HIGH, 32'h4);
        waitRise();
        wr(`LPO_OFS_CTRL, 32'h0000_0037);
        rd("statPend", `LPO_OFS_STAT, 32'h3);
        phases(16'(4 * tick), 16'(4 * tick));
        wr(`LPO_OFS_MODE, 32'h1);
        wr(`LPO_OFS_PERIOD, 32'h4);
        wr(`LPO_OFS_HIGH, 32'h2);
        waitRise();
        wr(`LPO_OFS_CTRL, 32'h0000_0037);
        rd("statNow", `LPO_OFS_STAT, 32'h1);
        phases(16'(2 * tick), 16'(2 * tick));
        wr(`LPO_OFS_MODE, 32'h0);
        waitRise();
        r0 = rises;
        wr(`LPO_OFS_CTRL, 32'h0000_0031);
        repeat (30) @(posedge mclk);
        chk("softRise", 32'h1, {16'h0, rises - r0});
        chk("softHigh", 32'(2 * tick), {16'h0, highLen});
        chk("softLow", 32'(2 * tick), {16'h0, lowLen});
        pinIs(1'b1);
        rd("stat", `LPO_OFS_STAT, 32'h0);
        wr(`LPO_OFS_MODE, 32'h4);
        wr(`LPO_OFS_PERIOD, 32'h8);
        wr(`LPO_OFS_HIGH, 32'h4);
        wr(`LPO_OFS_CTRL, 32'h0000_0027);
        waitRise();
        wr(`LPO_OFS_CTRL, 32'h0000_0021);
        repeat (20) @(posedge mclk);
        chk("hardCut", 32'h1, {31'h0, highLen < 4 * tick});
        pinIs(1'b0);
        wr(`LPO_OFS_MODE, 32'h0);
        wr(`LPO_OFS_CTRL, 32'h0000_0023);
        waitRise();
        wr(`LPO_OFS_CTRL, 32'h0000_002b);
        repeat (20) @(posedge mclk);
        chk("resetCut", 32'h1, {31'h0, highLen < 4 * tick});
        rd("stat", `LPO_OFS_STAT, 32'h0);
        wr(`LPO_OFS_MODE, 32'h2);
        wr(`LPO_OFS_COUNT, 32'h3);
        r0 = rises;
        wr(`LPO_OFS_CTRL, 32'h0000_0023);
        repeat (3 * 8 * tick + 20) @(posedge mclk);
        chk("periods", 32'h3, {16'h0, rises - r0});
        rd("stat", `LPO_OFS_STAT, 32'h0);
        pinIs(1'b0);
        wr(`LPO_OFS_MODE, 32'h0);
        wr(`LPO_OFS_CTRL, 32'h0000_0023);
        latency(t0);
        wr(`LPO_OFS_CTRL, 32'h0000_0029);
        wr(`LPO_OFS_DELAY, 32'h5);
        wr(`LPO_OFS_CTRL, 32'h0000_0023);
        latency(t5);
        chk("delay", 32'(5 * tick), 32'(t5 - t0));
        wr(`LPO_OFS_CTRL, 32'h0000_0029);
        tally_and_finish();
    end
endmodule

// ### bench/lpo_load_model.sv
// Load model that times the levels seen on the pulse output pin
`timescale 1ns/1ns
module lpo_load_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic pinIn,
    output logic [15:0] highLen,
    output logic [15:0] lowLen,
    output logic [15:0] rises
);
    logic [15:0] runLen_ff;
    logic [15:0] highLen_ff;
    logic [15:0] lowLen_ff;
    logic [15:0] rises_ff;
    logic level_ff;
    assign highLen = highLen_ff;
    assign lowLen = lowLen_ff;
    assign rises = rises_ff;
    // --------------------------------------------------
    // Phase timer: length of the last finished phase
    // --------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            runLen_ff <= 16'h0001;
            highLen_ff <= 16'h0000;
            lowLen_ff <= 16'h0000;
            rises_ff <= 16'h0000;
            level_ff <= 1'b0;
        end else if (pinIn !== level_ff) begin
            if (level_ff) begin
                highLen_ff <= runLen_ff;
            end else begin
                lowLen_ff <= runLen_ff;
            end
            if (pinIn === 1'b1) begin
                rises_ff <= rises_ff + 16'h0001;
            end
            runLen_ff <= 16'h0001;
            level_ff <= pinIn;
        end else begin
            runLen_ff <= runLen_ff + 16'h0001;
        end
    end
endmodule

// ### common/lpo_map.svh
// Register map, field positions and timing of the pulse output unit
// Notes on behaviour
// - Select 1 routes generator, 0 plain output
// - After power-up pin is plain output
// - Enable 1 starts, 0 stops generation
// - Disable stops now or at period end
// - Routed but disabled pin shows standby level
// - Run status 1 running, 0 finished
// - Start delay counted in 25 ns steps; code counts ticks of 3 mclk cycles (30 ns)
// - Each cycle begins at programmed start level
// - Mode bit 0 picks takeover moment
// - Mode bit 1 picks endless or counted run
// - Period count positive, used only counted
// - Mode bit 2 picks soft or hard stop
// - Frequency and duty held until commit 1
// - Committed values apply now or period end
// - Reset request 1 halts output at once
// - Stopped output shows the standby level
// - Standby 0 low, 1 high, low after power-up
// - One percent duty steps up to 400 kHz; the 30 ns tick gives this only up to about 333 kHz
`ifndef LPO_MAP_SVH
`define LPO_MAP_SVH
`define LPO_OFS_CTRL 8'h00
`define LPO_OFS_MODE 8'h04
`define LPO_OFS_COUNT 8'h08
`define LPO_OFS_DELAY 8'h0c
`define LPO_OFS_PERIOD 8'h10
`define LPO_OFS_HIGH 8'h14
`define LPO_OFS_STAT 8'h18
`define LPO_LAST_IDX 6'h06
`define LPO_CTRL_SEL 0
`define LPO_CTRL_EN 1
`define LPO_CTRL_COMMIT 2
`define LPO_CTRL_RESET 3
`define LPO_CTRL_STBY 4
`define LPO_CTRL_START 5
`define LPO_CTRL_DOUT 6
`define LPO_MODE_TAKE 0
`define LPO_MODE_FINITE 1
`define LPO_MODE_HALT 2
`define LPO_STAT_RUN 0
`define LPO_STAT_PEND 1
`define LPO_RST_COUNT 32'h0000_0001
`define LPO_RST_PERIOD 32'h0000_0002
`define LPO_RST_HIGH 32'h0000_0001
`define LPO_CLK_NS 10
`define LPO_TICK_NS 25
`define LPO_TICK_CYC ((`LPO_TICK_NS + `LPO_CLK_NS - 1) / `LPO_CLK_NS)
`define LPO_RESP_OK 2'b00
`define LPO_RESP_ERR 2'b10
`endif

// ### common/lpo_pkg.sv
// Types shared by the pulse output unit
package lpo_pkg;
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } lpo_axi_req_type;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } lpo_axi_rsp_type;
    typedef enum logic [1:0] {GEN_IDLE, GEN_WAIT, GEN_RUN} lpo_gen_type;
endpackage

// ### hdl/lpo_top.sv
// Pulse output unit with holding latch behind an AXI4-Lite slave
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "lpo_map.svh"
module lpo_top #(
    parameter int DLY_W = 32,
    parameter int PER_W = 32,
    parameter int CNT_W = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire lpo_pkg::lpo_axi_req_type axiReq,
    output lpo_pkg::lpo_axi_rsp_type axiRsp,
    output logic pinOut
);
    import lpo_pkg::*;

    localparam int TICK_CYC = `LPO_TICK_CYC;
    localparam logic [1:0] TICK_LAST = 2'(TICK_CYC - 1);

    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    function automatic logic [31:0] mergeStrb(
        input logic [31:0] old,
        input logic [31:0] dat,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = dat[8*i +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic isMapped(input logic [7:0] adr);
        return adr[7:2] <= `LPO_LAST_IDX;
    endfunction

    function automatic logic hit(
        input logic [7:0] adr,
        input logic [7:0] ofs
    );
        return adr[7:2] == ofs[7:2];
    endfunction

    // ------------------------------------------------
    // Declarations
    // ------------------------------------------------
    logic awrdyFf, wrdyFf, bvalFf, arrdyFf, rvalFf;
    logic [1:0] brespFf, rrespFf;
    logic [31:0] rdataFf, rdMux, newWord;
    logic wrGo, rdGo, wrCtrl;
    logic selFf, enFf, stbyFf, startFf, doutFf;
    logic [2:0] modeFf;
    logic [CNT_W-1:0] cntFf, leftFf;
    logic [DLY_W-1:0] dlyFf, waitFf;
    logic [PER_W-1:0] holdPerFf, holdHighFf;
    logic [PER_W-1:0] actPerFf, actHighFf, phaseFf, lastPhase;
    logic [1:0] tickFf;
    lpo_gen_type genState;
    logic stopPendFf, latchPendFf;
    logic startPulse, stopPulse, commitPulse, rstPulse;
    logic tickEnd, perEnd, loadNow, loadEnd;
    logic runLvl, nxt_pin, pinFf;

    // ------------------------------------------------
    // Bus write channel
    // ------------------------------------------------
    assign wrGo = awrdyFf && axiReq.awvalid
        && wrdyFf && axiReq.wvalid;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            awrdyFf <= 1'b0;
            wrdyFf <= 1'b0;
            bvalFf <= 1'b0;
            brespFf <= `LPO_RESP_OK;
        end else begin
            awrdyFf <= 1'b0;
            wrdyFf <= 1'b0;
            if (!awrdyFf && !bvalFf && axiReq.awvalid
                && axiReq.wvalid) begin
                awrdyFf <= 1'b1;
                wrdyFf <= 1'b1;
            end
            if (wrGo) begin
                bvalFf <= 1'b1;
                brespFf <= isMapped(axiReq.awaddr)
                    ? `LPO_RESP_OK : `LPO_RESP_ERR;
            end else if (bvalFf && axiReq.bready) begin
                bvalFf <= 1'b0;
            end
        end
    end

    // ------------------------------------------------
    // Bus read channel
    // ------------------------------------------------
    assign rdGo = arrdyFf && axiReq.arvalid;

    always_comb begin
        rdMux = 32'h0000_0000;
        if (hit(axiReq.araddr, `LPO_OFS_CTRL)) begin
            rdMux[`LPO_CTRL_SEL] = selFf;
            rdMux[`LPO_CTRL_EN] = enFf;
            rdMux[`LPO_CTRL_STBY] = stbyFf;
            rdMux[`LPO_CTRL_START] = startFf;
            rdMux[`LPO_CTRL_DOUT] = doutFf;
        end else if (hit(axiReq.araddr, `LPO_OFS_MODE)) begin
            rdMux[2:0] = modeFf;
        end else if (hit(axiReq.araddr, `LPO_OFS_COUNT)) begin
            rdMux[CNT_W-1:0] = cntFf;
        end else if (hit(axiReq.araddr, `LPO_OFS_DELAY)) begin
            rdMux[DLY_W-1:0] = dlyFf;
        end else if (hit(axiReq.araddr, `LPO_OFS_PERIOD)) begin
            rdMux[PER_W-1:0] = holdPerFf;
        end else if (hit(axiReq.araddr, `LPO_OFS_HIGH)) begin
            rdMux[PER_W-1:0] = holdHighFf;
        end else if (hit(axiReq.araddr, `LPO_OFS_STAT)) begin
            rdMux[`LPO_STAT_RUN] = genState != GEN_IDLE;
            rdMux[`LPO_STAT_PEND] = latchPendFf;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            arrdyFf <= 1'b0;
            rvalFf <= 1'b0;
            rdataFf <= 32'h0000_0000;
            rrespFf <= `LPO_RESP_OK;
        end else begin
            arrdyFf <= !arrdyFf && !rvalFf && axiReq.arvalid;
            if (rdGo) begin
                rvalFf <= 1'b1;
                rdataFf <= rdMux;
                rrespFf <= isMapped(axiReq.araddr)
                    ? `LPO_RESP_OK : `LPO_RESP_ERR;
            end else if (rvalFf && axiReq.rready) begin
                rvalFf <= 1'b0;
            end
        end
    end

    assign axiRsp.awready = awrdyFf;
    assign axiRsp.wready = wrdyFf;
    assign axiRsp.bvalid = bvalFf;
    assign axiRsp.bresp = brespFf;
    assign axiRsp.arready = arrdyFf;
    assign axiRsp.rvalid = rvalFf;
    assign axiRsp.rdata = rdataFf;
    assign axiRsp.rresp = rrespFf;

    // ------------------------------------------------
    // Control registers
    // ------------------------------------------------
    assign wrCtrl = wrGo && hit(axiReq.awaddr, `LPO_OFS_CTRL);
    assign newWord = mergeStrb(32'h0000_0000, axiReq.wdata,
        axiReq.wstrb);

    assign startPulse = wrCtrl && newWord[`LPO_CTRL_EN]
        && genState == GEN_IDLE;
    assign stopPulse = wrCtrl && !newWord[`LPO_CTRL_EN]
        && axiReq.wstrb[0] && genState != GEN_IDLE;
    assign commitPulse = wrCtrl && newWord[`LPO_CTRL_COMMIT];
    // reset request of 0 does nothing
    assign rstPulse = wrCtrl && newWord[`LPO_CTRL_RESET];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            selFf <= 1'b0;
            enFf <= 1'b0;
            stbyFf <= 1'b0;
            startFf <= 1'b0;
            doutFf <= 1'b0;
        end else if (wrCtrl && axiReq.wstrb[0]) begin
            selFf <= newWord[`LPO_CTRL_SEL];
            enFf <= newWord[`LPO_CTRL_EN];
            stbyFf <= newWord[`LPO_CTRL_STBY];
            startFf <= newWord[`LPO_CTRL_START];
            doutFf <= newWord[`LPO_CTRL_DOUT];
        end else if (genState == GEN_IDLE) begin
            enFf <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            modeFf <= 3'h0;
            cntFf <= CNT_W'(`LPO_RST_COUNT);
            dlyFf <= '0;
            holdPerFf <= PER_W'(`LPO_RST_PERIOD);
            holdHighFf <= PER_W'(`LPO_RST_HIGH);
        end else if (wrGo) begin
            if (hit(axiReq.awaddr, `LPO_OFS_MODE)) begin
                modeFf <= 3'(mergeStrb(32'(modeFf),
                    axiReq.wdata, axiReq.wstrb));
            end
            if (hit(axiReq.awaddr, `LPO_OFS_COUNT)) begin
                cntFf <= CNT_W'(mergeStrb(32'(cntFf),
                    axiReq.wdata, axiReq.wstrb));
            end
            if (hit(axiReq.awaddr, `LPO_OFS_DELAY)) begin
                dlyFf <= DLY_W'(mergeStrb(32'(dlyFf),
                    axiReq.wdata, axiReq.wstrb));
            end
            // writes reach the holding latch only
            if (hit(axiReq.awaddr, `LPO_OFS_PERIOD)) begin
                holdPerFf <= PER_W'(mergeStrb(32'(holdPerFf),
                    axiReq.wdata, axiReq.wstrb));
            end
            if (hit(axiReq.awaddr, `LPO_OFS_HIGH)) begin
                holdHighFf <= PER_W'(mergeStrb(32'(holdHighFf),
                    axiReq.wdata, axiReq.wstrb));
            end
        end
    end

    // ------------------------------------------------
    // Tick and period timing
    // ------------------------------------------------
    // one count per tick of 3 mclk cycles (30 ns)
    // duty resolution set by the tick
    assign tickEnd = tickFf == TICK_LAST;
    assign lastPhase = (actPerFf == '0) ? '0
        : actPerFf - PER_W'(1);
    assign perEnd = genState == GEN_RUN && tickEnd
        && phaseFf >= lastPhase;

    // ------------------------------------------------
    // Holding latch takeover
    // ------------------------------------------------
    // mode bit 0 picks the moment
    assign loadNow = commitPulse
        && (modeFf[`LPO_MODE_TAKE] || genState != GEN_RUN);
    assign loadEnd = latchPendFf && perEnd;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            actPerFf <= PER_W'(`LPO_RST_PERIOD);
            actHighFf <= PER_W'(`LPO_RST_HIGH);
            latchPendFf <= 1'b0;
        end else begin
            if (loadNow || loadEnd) begin
                actPerFf <= holdPerFf;
                actHighFf <= holdHighFf;
            end
            if (commitPulse && !loadNow) begin
                latchPendFf <= 1'b1;
            end else if (loadEnd || loadNow) begin
                latchPendFf <= 1'b0;
            end
        end
    end

    // ------------------------------------------------
    // Generator state machine
    // ------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            genState <= GEN_IDLE;
            tickFf <= 2'h0;
            phaseFf <= '0;
            waitFf <= '0;
            leftFf <= '0;
            stopPendFf <= 1'b0;
        end else if (rstPulse) begin
            genState <= GEN_IDLE;
            stopPendFf <= 1'b0;
        end else begin
            tickFf <= tickEnd ? 2'h0 : tickFf + 2'h1;
            case (genState)
                GEN_IDLE: begin
                    tickFf <= 2'h0;
                    if (startPulse) begin
                        genState <= GEN_WAIT;
                        waitFf <= dlyFf;
                    end
                end
                GEN_WAIT: begin
                    if (stopPulse) begin
                        genState <= GEN_IDLE;
                    end else if (waitFf == '0) begin
                        genState <= GEN_RUN;
                        tickFf <= 2'h0;
                        phaseFf <= '0;
                        leftFf <= cntFf;
                    end else if (tickEnd) begin
                        waitFf <= waitFf - DLY_W'(1);
                    end
                end
                GEN_RUN: begin
                    if (stopPulse && modeFf[`LPO_MODE_HALT]) begin
                        genState <= GEN_IDLE;
                        stopPendFf <= 1'b0;
                    end else if (perEnd) begin
                        phaseFf <= '0;
                        if (stopPendFf || stopPulse
                            || (modeFf[`LPO_MODE_FINITE]
                            && leftFf <= CNT_W'(1))) begin
                            genState <= GEN_IDLE;
                            stopPendFf <= 1'b0;
                        end else begin
                            leftFf <= leftFf - CNT_W'(1);
                        end
                    end else begin
                        if (stopPulse) begin
                            stopPendFf <= 1'b1;
                        end
                        if (tickEnd) begin
                            phaseFf <= phaseFf + PER_W'(1);
                        end
                        if (loadNow) begin
                            phaseFf <= '0;
                            tickFf <= 2'h0;
                        end
                    end
                end
                default: begin
                    genState <= GEN_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------
    // Pin output
    // ------------------------------------------------
    // period opens at the start level
    // held value is time at start level
    assign runLvl = (phaseFf < actHighFf) ? startFf : !startFf;

    always_comb begin
        if (!selFf) begin
            nxt_pin = doutFf;
        end else if (genState == GEN_RUN) begin
            nxt_pin = runLvl;
        end else begin
            nxt_pin = stbyFf;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinFf <= 1'b0;
        end else begin
            pinFf <= nxt_pin;
        end
    end

    assign pinOut = pinFf;

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    default clocking dcb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    pin_mux_dig_a: assert property (
        !selFf |=> pinOut == $past(doutFf))
        else $error("plain output level wrong");
    pin_boot_a: assert property (
        !selFf && !wrCtrl |=> !selFf)
        else $error("pin select changed unwritten");
    wait_hold_a: assert property (
        genState == GEN_WAIT && waitFf != '0 && !stopPulse
        && !rstPulse |=> genState == GEN_WAIT)
        else $error("start delay cut short");
    hard_stop_a: assert property (
        genState == GEN_RUN && stopPulse
        && modeFf[`LPO_MODE_HALT] |=> genState == GEN_IDLE)
        else $error("hard stop not immediate");
    soft_stop_a: assert property (
        genState == GEN_RUN && stopPulse && !perEnd && !rstPulse
        && !modeFf[`LPO_MODE_HALT] |=> genState == GEN_RUN
        && stopPendFf)
        else $error("soft stop ended period early");
    reset_req_a: assert property (
        rstPulse |=> genState == GEN_IDLE ##1 pinOut == ($past(selFf)
        ? $past(stbyFf) : $past(doutFf)))
        else $error("reset request did not halt");
    standby_pin_a: assert property (
        selFf && genState != GEN_RUN |=> pinOut == $past(stbyFf))
        else $error("standby level missing");
    start_lvl_a: assert property (
        selFf && genState == GEN_RUN && phaseFf == '0
        && actHighFf != '0 |=> pinOut == $past(startFf))
        else $error("period not at start level");
    count_end_a: assert property (
        perEnd && modeFf[`LPO_MODE_FINITE] && leftFf == CNT_W'(1)
        && !rstPulse |=> genState == GEN_IDLE)
        else $error("counted run did not finish");
    latch_hold_a: assert property (
        !loadNow && !loadEnd |=> $stable(actPerFf)
        && $stable(actHighFf))
        else $error("active values changed uncommitted");
    commit_now_a: assert property (
        loadNow |=> actPerFf == $past(holdPerFf)
        && !latchPendFf)
        else $error("immediate takeover failed");
    tick_pace_a: assert property (
        genState == GEN_RUN && !tickEnd && !loadNow
        |=> $stable(phaseFf))
        else $error("phase moved between ticks");
    run_status_a: assert property (
        rdGo && hit(axiReq.araddr, `LPO_OFS_STAT) |=>
        rdataFf[`LPO_STAT_RUN] == ($past(genState) != GEN_IDLE))
        else $error("run status wrong");

    start_seen_c: cover property (
        startPulse ##[1:20] genState == GEN_RUN);
    count_done_c: cover property (
        perEnd && modeFf[`LPO_MODE_FINITE] ##1
        genState == GEN_IDLE);
    late_take_c: cover property (loadEnd);
    soft_stop_c: cover property (
        stopPendFf ##[1:40] genState == GEN_IDLE);
endmodule
